/* shared/scf_defs.svh */
// Register offsets, field positions, reset values and constants of the shared buffer core.
// Assumes inclusion by its bare name from the core.
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH
`define SCF_DEPTH 64
`define SCF_OFS_DATA 8'h00
`define SCF_OFS_FILL 8'h04
`define SCF_OFS_THRESH 8'h08
`define SCF_OFS_STATUS 8'h0C
`define SCF_OFS_ERROR 8'h10
`define SCF_OFS_EVT_EN 8'h14
`define SCF_OFS_EVT_FLAG 8'h18
`define SCF_OFS_MISC_EN 8'h1C
`define SCF_OFS_MISC_FLAG 8'h20
`define SCF_OFS_MODE 8'h24
`define SCF_OFS_CRC_HI 8'h28
`define SCF_OFS_CRC_LO 8'h2C
`define SCF_OFS_CMD 8'h30
`define SCF_FILL_CLEAR_BIT 7
`define SCF_FLAG_SET_BIT 7
`define SCF_EVT_TIMER 0
`define SCF_EVT_ERR 1
`define SCF_EVT_AEMPTY 2
`define SCF_EVT_AFULL 3
`define SCF_EVT_IDLE 4
`define SCF_EVT_RX 5
`define SCF_EVT_TX 6
`define SCF_MISC_CRC 2
`define SCF_ST_AEMPTY 0
`define SCF_ST_AFULL 1
`define SCF_ST_CRC_DONE 5
`define SCF_ST_IRQ 4
`define SCF_ERR_OVERRUN 4
`define SCF_MODE_MSB_BIT 3
`define SCF_CMD_IDLE 4'h0
`define SCF_CMD_CALC 4'h3
`define SCF_POLY 16'h1021
`define SCF_SEED0 16'h0000
`define SCF_SEED1 16'h6363
`define SCF_SEED2 16'hA671
`define SCF_SEED3 16'hFFFF
`define SCF_THRESH_RESET 6'h08
`define SCF_MODE_RESET 8'h01
`endif

/* shared/scf_pkg.sv */
// Types shared by the shared buffer core.
// Assumes the constants header is on the include path.
package scf_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } scf_req_type;
  typedef enum logic [0:0] {ST_IDLE, ST_CALC} scf_state_type;
endpackage

/* rtl/scf_core.sv */
// Shared 64-byte buffer with fill status, watermarks, checksum engine and event flags.
// Assumes a single AHB-Lite master, single word transfers and synchronous event inputs.
// What this block does
// - One 64 by 8 buffer shared by host and internal command logic.
// - Host write to data port stores one byte, write pointer plus one.
// - Host read of data port returns byte at read pointer, then advances.
// - Fill count, write minus read pointer, readable as seven bits.
// - Clear control resets pointers, count and overrun flag, discards bytes.
// - Overrun flag stays set until the buffer is cleared.
// - Almost-full is one when 64 minus count is at most threshold.
// - Almost-empty is one when count is at most the six-bit threshold.
// - Enabled watermark alert rising edge asserts the interrupt pin.
// - Checksum starts from 0000h, 6363h, A671h or FFFFh by seed select.
// - Checksum is sixteen bits with fixed polynomial x16+x12+x5+1.
// - Checksum result readable as upper and lower byte registers.
// - Bit-order control picks MSB first, else LSB first.
// - After consuming all bytes, checksum done status and flag are set.
// - Global status bit shows pending enabled events; pin follows it.
// - Timer flag sets when the timer counter goes from 1 to 0.
// - Transmit flag sets when sending moves from payload to end pattern.
// - Receive flag sets when the end of incoming data is seen.
// - Command done flag sets when a command returns to idle code.
// - Watermark event flags set when their alert status rises.
// - Error flag sets when any error bit is one during transfer.
// - Host may both set and clear the timer flag.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "scf_defs.svh"
module scf_core
  import scf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TIMER_DEC,
  input wire logic [15:0] TIMER_VALUE,
  input wire logic TX_EOF_START,
  input wire logic RX_END,
  input wire logic TXRX_ACTIVE,
  input wire logic [3:0] ERR_BITS,
  output logic IRQ
);
  scf_req_type req;
  logic pending;
  logic [7:0] mem [0:`SCF_DEPTH-1];
  logic [6:0] wr_ptr;
  logic [6:0] rd_ptr;
  logic [6:0] fill;
  logic [5:0] thresh;
  logic [6:0] evt_en;
  logic [6:0] evt_flag;
  logic misc_en;
  logic misc_flag;
  logic [7:0] mode;
  logic [3:0] command;
  logic [15:0] crc;
  logic crc_done;
  logic overrun;
  logic afull;
  logic aempty;
  logic afull_q;
  logic aempty_q;
  scf_state_type state;
  logic wr_cyc;
  logic rd_cyc;
  logic host_push;
  logic host_pop;
  logic crc_pop;
  logic clear;
  logic calc_start;
  logic calc_end;
  logic [6:0] evt_set;
  logic [6:0] evt_wset;
  logic [6:0] evt_wclr;
  logic misc_wset;
  logic misc_wclr;
  logic pend_any;
  logic [31:0] rdata;
  logic [15:0] seed;

  // Bytewise checksum update, one generator bit step per data bit.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                           input logic msb);
    logic [15:0] r;
    logic b;
    r = c;
    for (int i = 0; i < 8; i++) begin
      b = msb ? d[7-i] : d[i];
      r = {r[14:0], 1'b0} ^ ((b ^ r[15]) ? `SCF_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Bus access decode: a write or read takes effect in the first data phase cycle, the wait cycle.
  assign wr_cyc = pending && req.write;
  assign rd_cyc = pending && !req.write;
  assign fill = wr_ptr - rd_ptr;
  assign clear = wr_cyc && req.addr == `SCF_OFS_FILL && HWDATA[`SCF_FILL_CLEAR_BIT];
  assign host_push = wr_cyc && req.addr == `SCF_OFS_DATA && !clear;
  // The engine owns the read side while it runs, so host pops are ignored then.
  assign host_pop = rd_cyc && req.addr == `SCF_OFS_DATA && fill != 7'h00 && state == ST_IDLE;
  assign crc_pop = state == ST_CALC && fill != 7'h00;
  assign calc_start = wr_cyc && req.addr == `SCF_OFS_CMD && HWDATA[3:0] == `SCF_CMD_CALC
                      && state == ST_IDLE;
  assign calc_end = state == ST_CALC && fill == 7'h00;
  assign afull = (7'd64 - fill) <= {1'b0, thresh};
  assign aempty = fill <= {1'b0, thresh};
  assign evt_wset = (wr_cyc && req.addr == `SCF_OFS_EVT_FLAG && HWDATA[`SCF_FLAG_SET_BIT])
                    ? HWDATA[6:0] : 7'h00;
  assign evt_wclr = (wr_cyc && req.addr == `SCF_OFS_EVT_FLAG && !HWDATA[`SCF_FLAG_SET_BIT])
                    ? HWDATA[6:0] : 7'h00;
  assign misc_wset = wr_cyc && req.addr == `SCF_OFS_MISC_FLAG && HWDATA[`SCF_FLAG_SET_BIT]
                     && HWDATA[`SCF_MISC_CRC];
  assign misc_wclr = wr_cyc && req.addr == `SCF_OFS_MISC_FLAG && !HWDATA[`SCF_FLAG_SET_BIT]
                     && HWDATA[`SCF_MISC_CRC];
  assign pend_any = |(evt_flag & evt_en) || (misc_flag && misc_en);

  // Hardware event sources for the event flags.
  always_comb begin
    evt_set = 7'h00;
    evt_set[`SCF_EVT_TIMER] = TIMER_DEC && TIMER_VALUE == 16'h0001;
    evt_set[`SCF_EVT_ERR] = TXRX_ACTIVE && (|ERR_BITS || overrun);
    evt_set[`SCF_EVT_AEMPTY] = aempty && !aempty_q;
    evt_set[`SCF_EVT_AFULL] = afull && !afull_q;
    evt_set[`SCF_EVT_IDLE] = calc_end;
    evt_set[`SCF_EVT_RX] = RX_END;
    evt_set[`SCF_EVT_TX] = TX_EOF_START;
  end

  // Seed selection for a new checksum run.
  always_comb begin
    case (mode[1:0])
      2'd0: seed = `SCF_SEED0;
      2'd1: seed = `SCF_SEED1;
      2'd2: seed = `SCF_SEED2;
      default: seed = `SCF_SEED3;
    endcase
  end

  // Read multiplexer, sampled into the data register in the data phase.
  always_comb begin
    rdata = 32'h00000000;
    case (req.addr)
      `SCF_OFS_DATA: rdata[7:0] = mem[rd_ptr[5:0]];
      `SCF_OFS_FILL: rdata[6:0] = fill;
      `SCF_OFS_THRESH: rdata[5:0] = thresh;
      `SCF_OFS_STATUS: begin
        rdata[`SCF_ST_AEMPTY] = aempty;
        rdata[`SCF_ST_AFULL] = afull;
        rdata[`SCF_ST_IRQ] = pend_any;
        rdata[`SCF_ST_CRC_DONE] = crc_done;
      end
      `SCF_OFS_ERROR: begin
        rdata[3:0] = ERR_BITS;
        rdata[`SCF_ERR_OVERRUN] = overrun;
      end
      `SCF_OFS_EVT_EN: rdata[6:0] = evt_en;
      `SCF_OFS_EVT_FLAG: rdata[6:0] = evt_flag;
      `SCF_OFS_MISC_EN: rdata[`SCF_MISC_CRC] = misc_en;
      `SCF_OFS_MISC_FLAG: rdata[`SCF_MISC_CRC] = misc_flag;
      `SCF_OFS_MODE: rdata[7:0] = mode;
      `SCF_OFS_CRC_HI: rdata[7:0] = crc[15:8];
      `SCF_OFS_CRC_LO: rdata[7:0] = crc[7:0];
      `SCF_OFS_CMD: rdata[3:0] = command;
      default: rdata = 32'h00000000;
    endcase
  end

  // Bus slave: every access takes one wait cycle, then answers OKAY.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pending <= 1'b0;
      req <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h00000000;
    end else begin
      pending <= 1'b0;
      HREADYOUT <= 1'b1;
      if (HSEL && HTRANS[1] && HREADY) begin
        pending <= 1'b1;
        req.addr <= {HADDR[7:2], 2'b00};
        req.write <= HWRITE;
        HREADYOUT <= 1'b0;
      end
      if (rd_cyc) begin
        HRDATA <= rdata;
      end
    end
  end

  // Buffer storage; a full buffer keeps its contents.
  always_ff @(posedge CLOCK) begin
    if (host_push && fill != 7'd64) begin
      mem[wr_ptr[5:0]] <= HWDATA[7:0];
    end
  end

  // Buffer pointers and overrun flag.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      overrun <= 1'b0;
    end else if (clear) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      overrun <= 1'b0;
    end else begin
      if (host_push && fill != 7'd64) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (host_push && fill == 7'd64) begin
        overrun <= 1'b1;
      end
      if (host_pop || crc_pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
    end
  end

  // Software control registers.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      thresh <= `SCF_THRESH_RESET;
      evt_en <= 7'h00;
      misc_en <= 1'b0;
      mode <= `SCF_MODE_RESET;
    end else if (wr_cyc) begin
      case (req.addr)
        `SCF_OFS_THRESH: thresh <= HWDATA[5:0];
        `SCF_OFS_EVT_EN: evt_en <= HWDATA[6:0];
        `SCF_OFS_MISC_EN: misc_en <= HWDATA[`SCF_MISC_CRC];
        `SCF_OFS_MODE: mode <= HWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Checksum engine: consumes one byte per cycle until the buffer is empty.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      command <= `SCF_CMD_IDLE;
      crc <= 16'h0000;
      crc_done <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (calc_start) begin
            state <= ST_CALC;
            command <= `SCF_CMD_CALC;
            crc <= seed;
            crc_done <= 1'b0;
          end
        end
        ST_CALC: begin
          if (crc_pop) begin
            crc <= crc_byte(crc, mem[rd_ptr[5:0]], mode[`SCF_MODE_MSB_BIT]);
          end else begin
            state <= ST_IDLE;
            command <= `SCF_CMD_IDLE;
            crc_done <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sticky event flags; a hardware set wins over a host clear in the same cycle.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_flag <= 7'h00;
      misc_flag <= 1'b0;
      afull_q <= 1'b0;
      aempty_q <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      evt_flag <= (evt_flag & ~evt_wclr) | evt_wset | evt_set;
      misc_flag <= (misc_flag && !misc_wclr) || misc_wset || calc_end;
      afull_q <= afull;
      aempty_q <= aempty;
      IRQ <= pend_any;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  sequence s_full_write;
    host_push && fill == 7'd64;
  endsequence
  sequence s_calc_finish;
    state == ST_CALC && fill == 7'h00;
  endsequence

  property p_push_count;
    host_push && fill != 7'd64 && !host_pop && !crc_pop |=> fill == $past(fill) + 7'h01;
  endproperty
  a_push_count: assert property (p_push_count) else $error("push did not raise fill");
  property p_pop_count;
    host_pop && !host_push |=> fill == $past(fill) - 7'h01;
  endproperty
  a_pop_count: assert property (p_pop_count) else $error("pop did not lower fill");
  property p_clear;
    clear |=> fill == 7'h00 && !overrun;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left data or overrun");
  property p_overrun_set;
    s_full_write |=> overrun && fill == 7'd64;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("full write not flagged");
  property p_overrun_hold;
    overrun && !clear |=> overrun;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");
  property p_afull;
    afull == (({1'b0, fill} + {2'b00, thresh}) >= 8'd64) && fill <= 7'd64;
  endproperty
  a_afull: assert property (p_afull) else $error("almost full wrong");
  property p_alert_irq;
    aempty && !aempty_q && evt_en[`SCF_EVT_AEMPTY] |=> ##1 IRQ;
  endproperty
  a_alert_irq: assert property (p_alert_irq) else $error("alert did not raise pin");
  property p_calc_done;
    s_calc_finish |=> crc_done && misc_flag && command == `SCF_CMD_IDLE
                      && evt_flag[`SCF_EVT_IDLE];
  endproperty
  a_calc_done: assert property (p_calc_done) else $error("checksum end not reported");
  property p_timer;
    TIMER_DEC && TIMER_VALUE == 16'h0001 |=> evt_flag[`SCF_EVT_TIMER];
  endproperty
  a_timer: assert property (p_timer) else $error("timer flag not set");
  property p_irq_follow;
    ##1 IRQ == $past(pend_any);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("pin not OR of flags");
endmodule

/* verif/scf_host.sv */
// Host model: an AHB-Lite master that issues single word transfers.
// Assumes HREADY is the slave's HREADYOUT fed back and tasks start just after an edge.
`timescale 1ns/1ps
module scf_host (
  input wire logic CLOCK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  // The bus starts idle with a word size and no select.
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end

  // Address phase held until taken, then the data phase until answered.
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= w ? d : ~HWDATA;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    q = HRDATA;
  endtask
endmodule

/* verif/test_scf_core.sv */
// Bench: drives the buffer core through the host model and checks it against a queue model.
// Assumes the core answers every access within a few cycles.
`timescale 1ns/1ps
module test_scf_core
  import scf_pkg::*;
;
  logic CLOCK = 1'b0;
  logic ARST_N = 1'b0;
  logic HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, rv;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic TIMER_DEC = 1'b0, TX_EOF_START = 1'b0, RX_END = 1'b0, TXRX_ACTIVE = 1'b0;
  logic [15:0] TIMER_VALUE = 16'h0;
  logic [3:0] ERR_BITS = 4'h0;
  logic [7:0] lfsr = 8'h4A;
  logic [7:0] q[$];
  logic [15:0] crc;
  logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
  int eb [4] = '{0, 1, 5, 6};
  int miscompares = 0, n_compared = 0, cycles = 0, n;

  // Clock of 50 ns period.
  always #25 CLOCK = ~CLOCK;

  scf_core i_scf_core (.CLOCK(CLOCK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_DEC(TIMER_DEC),
    .TIMER_VALUE(TIMER_VALUE), .TX_EOF_START(TX_EOF_START), .RX_END(RX_END),
    .TXRX_ACTIVE(TXRX_ACTIVE), .ERR_BITS(ERR_BITS), .IRQ(IRQ));
  scf_host i_scf_host (.CLOCK(CLOCK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));

  // Ends the run with the counts and the verdict.
  task end_sim();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  function logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  function logic [31:0] st(input int c, input logic p);
    return {27'h0, p, 2'h0, (64 - c) <= 8, c <= 8};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    i_scf_host.xfer(a, 1'b1, d, rv);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_scf_host.xfer(a, 1'b0, 32'h0, rv);
    chk(rv & m, e);
    chk({31'h0, HRESP}, 32'h0);
  endtask

  // Model keeps at most 64 bytes; a push beyond that is dropped.
  task push(input logic [7:0] b);
    wr(8'h00, {24'h0, b});
    if (q.size() < 64) q.push_back(b);
  endtask

  task flush();
    wr(8'h04, 32'h80);
    q.delete();
  endtask

  // Shift-left checksum step over one byte in the chosen bit order.
  task crc_byte(input logic [7:0] d, input logic msb);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = crc[15] ^ (msb ? d[7 - i] : d[i]);
      crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0);
    end
  endtask

  // Raises one event source for a cycle; g=0 gives the near miss for sources 0 and 1, and sources 2 and 3 ignore g.
  task ev(input int k, input logic g);
    @(posedge CLOCK);
    case (k)
      0: begin
        TIMER_VALUE <= g ? 16'h1 : 16'h2;
        TIMER_DEC <= 1'b1;
      end
      1: begin
        ERR_BITS <= 4'(rnd()) | 4'h1;
        TXRX_ACTIVE <= g;
      end
      2: RX_END <= 1'b1;
      default: TX_EOF_START <= 1'b1;
    endcase
    @(posedge CLOCK);
    {TIMER_DEC, RX_END, TX_EOF_START, TXRX_ACTIVE, ERR_BITS} <= 8'h0;
    repeat (3) @(posedge CLOCK);
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge CLOCK);
    ARST_N <= 1'b1;
    @(posedge CLOCK);
    rc(8'h08, 32'hFF, 32'h08);
    rc(8'h24, 32'hFF, 32'h01);
    rc(8'h18, 32'h7F, 32'h04);
    rc(8'h3C, 32'hFFFFFFFF, 32'h0);
    wr(8'h14, 32'h08);
    wr(8'h18, 32'h7F);
    for (int i = 0; i < 65; i++) begin
      push(rnd());
      rc(8'h04, 32'h7F, 32'(q.size()));
      rc(8'h0C, 32'h13, st(q.size(), q.size() >= 56));
      chk({31'h0, IRQ}, 32'(q.size() >= 56));
    end
    rc(8'h10, 32'h10, 32'h10);
    for (int i = 0; i < 10; i++) rc(8'h00, 32'hFF, {24'h0, q.pop_front()});
    rc(8'h10, 32'h10, 32'h10);
    flush();
    rc(8'h04, 32'h7F, 32'h0);
    rc(8'h10, 32'h10, 32'h0);
    for (int i = 0; i < 64; i++) push(rnd());
    rc(8'h04, 32'h7F, 32'd64);
    for (int i = 0; i < 64; i++) rc(8'h00, 32'hFF, {24'h0, q.pop_front()});
    wr(8'h18, 32'h08);
    rc(8'h0C, 32'h10, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    // Almost-empty alert: lift the count above a zero threshold, then raise the threshold.
    wr(8'h14, 32'h04);
    wr(8'h08, 32'h00);
    push(rnd());
    wr(8'h18, 32'h7F);
    rc(8'h0C, 32'h13, 32'h00);
    chk({31'h0, IRQ}, 32'h0);
    wr(8'h08, 32'h08);
    rc(8'h18, 32'h7F, 32'h04);
    chk({31'h0, IRQ}, 32'h1);
    flush();
    wr(8'h18, 32'h7F);
    wr(8'h14, 32'h63);
    for (int k = 0; k < 4; k++) begin
      for (int g = (k < 2) ? 0 : 1; g < 2; g++) begin
        wr(8'h18, 32'h7F);
        ev(k, g[0]);
        rc(8'h18, 32'h7F, 32'(g) << eb[k]);
        chk({31'h0, IRQ}, 32'(g));
      end
    end
    wr(8'h18, 32'h7F);
    wr(8'h18, 32'h81);
    rc(8'h18, 32'h7F, 32'h01);
    wr(8'h18, 32'h01);
    rc(8'h18, 32'h7F, 32'h0);
    // Checksum flag set by the host, with its enable feeding the pin.
    wr(8'h1C, 32'h04);
    wr(8'h20, 32'h84);
    rc(8'h20, 32'h04, 32'h04);
    chk({31'h0, IRQ}, 32'h1);
    wr(8'h20, 32'h04);
    rc(8'h0C, 32'h10, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    wr(8'h1C, 32'h0);
    wr(8'h14, 32'h0);
    for (int s = 0; s < 8; s++) begin
      crc = seeds[s % 4];
      flush();
      wr(8'h24, {28'h0, s[2], 1'b0, s[1:0]});
      for (int i = 0; i < 3; i++) begin
        logic [7:0] b;
        b = rnd();
        push(b);
        crc_byte(b, s[2]);
      end
      wr(8'h20, 32'h04);
      wr(8'h18, 32'h7F);
      wr(8'h30, 32'h3);
      n = 0;
      // Only the command register is polled while the checksum runs.
      do begin
        i_scf_host.xfer(8'h30, 1'b0, 32'h0, rv);
        n++;
      end while (rv[3:0] !== 4'h0 && n < 20);
      chk(rv, 32'h0);
      rc(8'h28, 32'hFF, {24'h0, crc[15:8]});
      rc(8'h2C, 32'hFF, {24'h0, crc[7:0]});
      rc(8'h0C, 32'h20, 32'h20);
      rc(8'h20, 32'h04, 32'h04);
      rc(8'h18, 32'h10, 32'h10);
      q.delete();
    end
    end_sim();
  end
endmodule
